// ---- hw/occ_pkg.sv ----
// Constants for the output compare control word block.
`default_nettype none
package occ_pkg;
	// Register indices on the plain register port
	localparam logic [3:0] OCC_ADDR_CTRL2 = 4'h0;
	localparam logic [3:0] OCC_ADDR_MODE = 4'h1;
	localparam logic [3:0] OCC_ADDR_STAT = 4'h2;
	localparam logic [3:0] OCC_ADDR_MASK = 4'h3;
	// Control word field positions
	localparam int OCC_B_HOLD = 15;
	localparam int OCC_B_FLEVEL = 14;
	localparam int OCC_B_FDIR = 13;
	localparam int OCC_B_INV = 12;
	localparam int OCC_B_FRAC_HI = 10;
	localparam int OCC_B_FRAC_LO = 9;
	localparam int OCC_B_CASC = 8;
	localparam int OCC_B_TRIG = 7;
	localparam int OCC_B_TRUN = 6;
	localparam int OCC_B_TRIS = 5;
	localparam int OCC_B_SRC_HI = 4;
	// Control word reset value and implemented bits
	localparam logic [15:0] OCC_CTRL2_RST = 16'h000C;
	localparam logic [15:0] OCC_CTRL2_MASK = 16'hF7FF;
	// Mode register: compare mode in 2:0, fault latch flag in bit 4
	localparam int OCC_B_FLATCH = 4;
	localparam logic [2:0] OCC_MODE_RST = 3'h0;
	localparam logic [2:0] OCC_MODE_PWM_A = 3'h6;
	localparam logic [2:0] OCC_MODE_PWM_B = 3'h7;
	// Interrupt status bits
	localparam int OCC_I_FAULT = 0;
	localparam int OCC_I_TRIG = 1;
	localparam logic [1:0] OCC_IRQ_RST = 2'h0;
	localparam logic [1:0] OCC_FRAC_RST = 2'h0;
	localparam logic [15:0] OCC_ZERO16 = 16'h0000;
	// Quarter step delay line length
	localparam int OCC_DLY_LEN = 3;
endpackage
`default_nettype wire

// ---- hw/occ_top.sv ----
// Output compare second control word: fault, invert, fraction, cascade, trigger, tri-state.
//
// Our own choices: the plain strobed port and the placing of the registers.
`default_nettype none
// Overview of operation
// - With hold select set, fault mode lasts until the fault is gone and the latch flag is cleared; otherwise until the fault is gone and a new period starts.
// - During a fault the output is driven to the fault drive level.
// - With direction select set a fault forces the pin to an output; otherwise the pin direction is left alone.
// - The output invert bit inverts the compare output.
// - The duty fraction field delays the output edge by zero to three quarters of an instruction cycle.
// - The duty fraction is double-buffered to the period start only in the PWM modes 110 and 111.
// - Cascade enable joins an odd and an even channel for 32-bit operation.
// - Trigger select 1 triggers the channel from the chosen source; 0 synchronises it to that source.
// - The trigger running flag is set by hardware once triggered and reads 0 while not triggered.
// - The tri-state select bit floats the compare pin; clear, the channel drives it.
// - Reset clears all implemented control bits except source select bits 3 and 2, which reset to 1.
module occ_top
	import occ_pkg::*;
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire logic compare_raw,
	input wire logic period_start,
	input wire logic source_event,
	input wire logic fault_pin,
	output logic compare_output,
	output logic compare_output_oe_n,
	output logic cascade_enable,
	output logic [4:0] source_select_field,
	output logic timer_run,
	output logic sync_pulse,
	output logic irq
);
	logic [15:0] ctrl_reg;
	logic [15:0] ctrl_next;
	logic [2:0] mode_reg;
	logic latch_reg;
	logic latch_next;
	logic [1:0] stat_reg;
	logic [1:0] stat_next;
	logic [1:0] mask_reg;
	logic [1:0] frac_reg;
	logic [1:0] frac_next;
	logic fault_reg;
	logic fault_next;
	logic [2:0] fsync_reg;
	logic fclean_reg;
	logic [OCC_DLY_LEN-1:0] dly_reg;
	logic [15:0] rdata_reg;
	logic out_reg;
	logic oe_n_reg;
	logic run_reg;
	logic sync_reg;
	logic irq_reg;

	// Address decode
	wire sel_ctrl = reg_addr == OCC_ADDR_CTRL2;
	wire sel_mode = reg_addr == OCC_ADDR_MODE;
	wire sel_stat = reg_addr == OCC_ADDR_STAT;
	wire sel_mask = reg_addr == OCC_ADDR_MASK;
	wire wr_ctrl = reg_wr && sel_ctrl;
	wire wr_mode = reg_wr && sel_mode;
	wire wr_mask = reg_wr && sel_mask;
	wire rd_stat = reg_rd && sel_stat;

	// Control fields
	wire hold_sel = ctrl_reg[OCC_B_HOLD];
	wire flevel = ctrl_reg[OCC_B_FLEVEL];
	wire fdir = ctrl_reg[OCC_B_FDIR];
	wire inv = ctrl_reg[OCC_B_INV];
	wire [1:0] frac_field = ctrl_reg[OCC_B_FRAC_HI:OCC_B_FRAC_LO];
	wire trig_sel = ctrl_reg[OCC_B_TRIG];
	wire trun = ctrl_reg[OCC_B_TRUN];
	wire tris = ctrl_reg[OCC_B_TRIS];
	wire pwm_mode = (mode_reg == OCC_MODE_PWM_A) || (mode_reg == OCC_MODE_PWM_B);

	// Fault filter: a change counts once stages two and three agree
	wire fault_seen = fclean_reg;
	wire fault_enter = fault_seen && !fault_reg;

	// Fault exit condition depends on hold select
	wire fault_exit = hold_sel ? (!fault_seen && !latch_reg)
		: (!fault_seen && period_start);
	assign fault_next = fault_seen ? 1'b1 : (fault_reg && !fault_exit);

	// Latch flag: hardware set wins over a software clear
	wire latch_clr = wr_mode && !reg_wdata[OCC_B_FLATCH];
	assign latch_next = fault_seen || (latch_reg && !latch_clr);

	// Trigger running: set by source in trigger mode, held clear in sync mode
	wire trig_hit = trig_sel && source_event && !trun;
	wire trun_wr = wr_ctrl ? reg_wdata[OCC_B_TRUN] : trun;
	wire trun_next = trig_sel && (trun_wr || (trig_sel && source_event));

	// Control word next value; reserved bit stays zero
	wire [15:0] ctrl_wr = wr_ctrl ? (reg_wdata & OCC_CTRL2_MASK) : ctrl_reg;
	always_comb begin
		ctrl_next = ctrl_wr;
		ctrl_next[OCC_B_TRUN] = trun_next;
	end

	// Active fraction: buffered to period start only in PWM modes
	wire frac_load = pwm_mode ? period_start : 1'b1;
	assign frac_next = frac_load ? frac_field : frac_reg;

	// Quarter step delay of the raw compare edge
	wire delayed = (frac_reg == 2'h0) ? compare_raw : dly_reg[frac_reg - 2'h1];
	wire level = delayed ^ inv;
	wire out_next = fault_next ? flevel : level;
	// A forced direction overrides the tri-state select during a fault
	wire oe_n_next = (fault_next && fdir) ? 1'b0 : tris;

	// Interrupt events, set wins over the read clear
	wire [1:0] ev = {trig_hit, fault_enter};
	assign stat_next = ev | (rd_stat ? OCC_IRQ_RST : stat_reg);

	// Read mux, unmapped reads as zero
	wire [15:0] rd_mux = sel_ctrl ? ctrl_reg
		: sel_mode ? {11'h000, latch_reg, 1'b0, mode_reg}
		: sel_stat ? {14'h0000, stat_reg}
		: sel_mask ? {14'h0000, mask_reg}
		: OCC_ZERO16;

	// Three stage fault pin synchroniser with agreement filter
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			fsync_reg <= 3'h0;
			fclean_reg <= 1'b0;
		end else begin
			fsync_reg <= {fsync_reg[1:0], fault_pin};
			if (fsync_reg[1] == fsync_reg[2]) begin
				fclean_reg <= fsync_reg[2];
			end
		end
	end

	// Register file
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ctrl_reg <= OCC_CTRL2_RST;
			mode_reg <= OCC_MODE_RST;
			latch_reg <= 1'b0;
			stat_reg <= OCC_IRQ_RST;
			mask_reg <= OCC_IRQ_RST;
		end else begin
			ctrl_reg <= ctrl_next;
			if (wr_mode) begin
				mode_reg <= reg_wdata[2:0];
			end
			latch_reg <= latch_next;
			stat_reg <= stat_next;
			if (wr_mask) begin
				mask_reg <= reg_wdata[1:0];
			end
		end
	end

	// Read data one cycle after the strobe, zero otherwise
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rdata_reg <= OCC_ZERO16;
		end else begin
			rdata_reg <= reg_rd ? rd_mux : OCC_ZERO16;
		end
	end

	// Output path and fault state
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			fault_reg <= 1'b0;
			frac_reg <= OCC_FRAC_RST;
			dly_reg <= '0;
			out_reg <= 1'b0;
			oe_n_reg <= 1'b0;
		end else begin
			fault_reg <= fault_next;
			frac_reg <= frac_next;
			dly_reg <= {dly_reg[OCC_DLY_LEN-2:0], compare_raw};
			out_reg <= out_next;
			oe_n_reg <= oe_n_next;
		end
	end

	// Timer control: trigger gates the run, sync restarts on the source
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			run_reg <= 1'b1;
			sync_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			run_reg <= trig_sel ? trun_next : 1'b1;
			sync_reg <= !trig_sel && source_event;
			irq_reg <= |(stat_next & mask_reg);
		end
	end

	assign reg_rdata = rdata_reg;
	assign compare_output = out_reg;
	assign compare_output_oe_n = oe_n_reg;
	// Cascade bit goes straight to the partner channel's joiner
	assign cascade_enable = ctrl_reg[OCC_B_CASC];
	// Source choice is software's; self-selection is not guarded here
	assign source_select_field = ctrl_reg[OCC_B_SRC_HI:0];
	assign timer_run = run_reg;
	assign sync_pulse = sync_reg;
	assign irq = irq_reg;

	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	sequence s_fault_gone_hold;
		!fault_seen && !latch_reg && hold_sel;
	endsequence
	sequence s_fault_gone_free;
		!fault_seen && period_start && !hold_sel;
	endsequence

	a_hold_exit: assert property ((fault_reg and s_fault_gone_hold) |=> !fault_reg)
		else $error("fault not released after latch clear");
	a_free_exit: assert property ((fault_reg and s_fault_gone_free) |=> !fault_reg)
		else $error("fault not released at period start");
	a_hold_stays: assert property (fault_reg && hold_sel && latch_reg |=> fault_reg)
		else $error("fault left while latch set");
	a_fault_level: assert property (fault_reg |-> compare_output == $past(flevel))
		else $error("fault level wrong");
	a_fault_dir: assert property (fault_reg && $past(fdir) |-> !compare_output_oe_n)
		else $error("fault did not force output");
	a_tris_float: assert property (!fault_next && tris |=> compare_output_oe_n)
		else $error("pin not tri-stated");
	a_invert: assert property (!fault_next && frac_reg == 2'h0 |=>
		compare_output == ($past(compare_raw) ^ $past(inv)))
		else $error("invert wrong");
	a_frac_delay: assert property (!fault_next && frac_reg == 2'h2 && !inv |=>
		compare_output == $past(compare_raw, 3))
		else $error("fraction delay wrong");
	a_frac_buffer: assert property (pwm_mode && !period_start |=> $stable(frac_reg))
		else $error("fraction changed mid period");
	a_trun_clear: assert property (!trig_sel |=> !ctrl_reg[OCC_B_TRUN])
		else $error("trigger flag set in sync mode");
	a_trun_set: assert property (trig_sel && source_event |=> ctrl_reg[OCC_B_TRUN] && timer_run)
		else $error("trigger flag not set");
	a_sync_pulse: assert property (!trig_sel && source_event |=> sync_pulse)
		else $error("sync pulse missing");

	// Fault entry and the latch flag; a set must never lose to a clear
	sequence s_fault_rise;
		fault_seen && !fault_reg;
	endsequence
	sequence s_latch_kept;
		latch_reg && !latch_clr;
	endsequence

	a_fault_enter: assert property (s_fault_rise |=> fault_reg && latch_reg)
		else $error("fault entry not taken");
	a_fault_event: assert property (s_fault_rise |=> stat_reg[OCC_I_FAULT])
		else $error("fault event not flagged");
	a_latch_wins: assert property (fault_seen && latch_clr |=> latch_reg)
		else $error("latch clear beat a fault");
	a_latch_kept: assert property (s_latch_kept |=> latch_reg)
		else $error("latch flag lost");
	a_free_stays: assert property (fault_reg && !hold_sel && !period_start |=> fault_reg)
		else $error("fault left before period start");
	a_drive_clear: assert property (!fault_next && !tris |=> !compare_output_oe_n)
		else $error("pin not driven");

	// Edge delay at the other fraction codes, and the direct fraction load outside the PWM modes
	a_frac_quarter: assert property (!fault_next && frac_reg == 2'h1 && !inv |=>
		compare_output == $past(compare_raw, 2))
		else $error("quarter delay wrong");
	a_frac_three: assert property (!fault_next && frac_reg == 2'h3 && !inv |=>
		compare_output == $past(compare_raw, 4))
		else $error("three quarter delay wrong");
	a_frac_direct: assert property (!pwm_mode |=> frac_reg == $past(frac_field))
		else $error("fraction not taken directly");

	// Cascade and source choice follow a control write
	a_casc_follow: assert property (wr_ctrl |=>
		cascade_enable == $past(reg_wdata[OCC_B_CASC]))
		else $error("cascade bit not taken");
	a_src_follow: assert property (wr_ctrl |=>
		source_select_field == $past(reg_wdata[OCC_B_SRC_HI:0]))
		else $error("source choice not taken");

	// Trigger start, run state and the reserved bit
	sequence s_trig_start;
		trig_sel && source_event && !trun;
	endsequence
	a_trig_event: assert property (s_trig_start |=> stat_reg[OCC_I_TRIG] && timer_run)
		else $error("trigger start not flagged");
	a_trun_hold: assert property (trig_sel && trun && !wr_ctrl |=> trun)
		else $error("trigger flag dropped");
	a_run_free: assert property (!trig_sel |=> timer_run)
		else $error("sync mode timer stopped");
	a_sync_quiet: assert property (trig_sel |=> !sync_pulse)
		else $error("sync pulse in trigger mode");
	a_reserved_zero: assert property ((ctrl_reg & ~OCC_CTRL2_MASK) == OCC_ZERO16)
		else $error("reserved control bit set");

	// Status clear and interrupt level
	a_stat_clear: assert property (rd_stat && ev == 2'h0 |=> stat_reg == OCC_IRQ_RST)
		else $error("status not cleared by read");
	a_irq_level: assert property (irq == |(stat_reg & $past(mask_reg)))
		else $error("interrupt level wrong");
endmodule
`default_nettype wire

// ---- bench/occ_load.sv ----
// Pin load model for the compare output pin.
`default_nettype none
module occ_load (
	input wire logic compare_output,
	input wire logic compare_output_oe_n,
	output logic pin_level
);
	timeunit 1ns;
	timeprecision 1ps;
	// Pull-down holds a floated pin low, so a stale value never shows
	assign pin_level = compare_output_oe_n ? 1'b0 : compare_output;
endmodule
`default_nettype wire

// ---- bench/tb_output_compare_control.sv ----
// Self-checking bench for the output compare control word block.
`default_nettype none
`define CHK(n, e, v) begin num_checks++; if ((v) !== (e)) begin n_fail++; \
$display("Error %s exp %h got %h", n, e, v); end end
module tb_output_compare_control
	import occ_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, compare_raw = 0;
	logic period_start = 0, source_event = 0, fault_pin = 0, rv = 0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000, w, e_rd, reg_rdata;
	logic compare_output, compare_output_oe_n, cascade_enable;
	logic timer_run, sync_pulse, irq, pin_level;
	logic [4:0] source_select_field;
	logic [15:0] expq[$];
	int n_fail = 0, num_checks = 0, d0, d;
	// Free running 200 MHz clock
	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end
	occ_top u_dut (.sys_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.compare_raw, .period_start, .source_event, .fault_pin, .compare_output,
		.compare_output_oe_n, .cascade_enable, .source_select_field, .timer_run,
		.sync_pulse, .irq);
	occ_load u_load (.compare_output, .compare_output_oe_n, .pin_level);
	// Read data stand only in the cycle after the strobe edge
	always @(posedge sys_clk) begin
		if (rv) begin
			e_rd = expq.pop_front();
			`CHK("rdata", e_rd, reg_rdata)
		end
		rv <= reg_rd;
	end
	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// One idle cycle after each strobe keeps every signal to one change per step
	task wr(input logic [3:0] a, input logic [15:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		cyc(1);
		reg_wr <= 1'b0;
		cyc(1);
	endtask
	task rd(input logic [3:0] a, input logic [15:0] v);
		reg_addr <= a;
		reg_rd <= 1'b1;
		expq.push_back(v);
		cyc(1);
		reg_rd <= 1'b0;
		cyc(1);
	endtask
	task pstart;
		period_start <= 1'b1;
		cyc(1);
		period_start <= 1'b0;
	endtask
	task sev;
		source_event <= 1'b1;
		cyc(1);
		source_event <= 1'b0;
	endtask
	// Cycles from a raw edge to the output edge
	task meas(output int n);
		logic t;
		cyc(6);
		t = compare_output;
		compare_raw <= ~compare_raw;
		n = 0;
		do begin
			cyc(1);
			n++;
		end while (compare_output === t && n < 20);
		if (n == 20) begin
			n_fail++;
			end_sim;
		end
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		void'($urandom(32'h44d5));
		cyc(10);
		srst <= 1'b0;
		cyc(1);
		rd(OCC_ADDR_CTRL2, 16'h000C);
		rd(4'h7, 16'h0000);
		`CHK("src", 5'h0C, source_select_field)
		`CHK("casc", 1'b0, cascade_enable)
		wr(OCC_ADDR_CTRL2, 16'hFFBF);
		rd(OCC_ADDR_CTRL2, 16'hF7BF);
		repeat (4) begin
			w = 16'($urandom) & 16'hF7BF;
			wr(OCC_ADDR_CTRL2, w);
			rd(OCC_ADDR_CTRL2, w);
			`CHK("casc", w[8], cascade_enable)
			`CHK("src", w[4:0], source_select_field)
		end
		wr(OCC_ADDR_CTRL2, 16'h0000);
		// Raw taken at the next edge, then one output stage
		d0 = 2;
		for (int f = 0; f < 4; f++) begin
			wr(OCC_ADDR_CTRL2, 16'(f << 9));
			meas(d);
			`CHK("delay", d0 + f, d)
		end
		wr(OCC_ADDR_CTRL2, 16'h1000);
		cyc(6);
		`CHK("inv", ~compare_raw, compare_output)
		// Both PWM codes hold a new fraction back to the period start
		for (int m = 6; m < 8; m++) begin
			wr(OCC_ADDR_MODE, 16'(m));
			wr(OCC_ADDR_CTRL2, 16'h0400);
			meas(d);
			`CHK("frac held", d0, d)
			pstart;
			meas(d);
			`CHK("frac load", d0 + 2, d)
			wr(OCC_ADDR_CTRL2, 16'h0000);
			pstart;
		end
		wr(OCC_ADDR_MODE, 16'h0000);
		wr(OCC_ADDR_CTRL2, 16'h0020);
		cyc(2);
		`CHK("oe_n", 1'b1, compare_output_oe_n)
		`CHK("pin", 1'b0, pin_level)
		// Held fault: drive high, force output, exit only after latch clear
		compare_raw <= 1'b0;
		wr(OCC_ADDR_MASK, 16'h0001);
		wr(OCC_ADDR_CTRL2, 16'hE020);
		fault_pin <= 1'b1;
		cyc(8);
		`CHK("flt lvl", 1'b1, compare_output)
		`CHK("flt dir", 1'b0, compare_output_oe_n)
		`CHK("irq", 1'b1, irq)
		fault_pin <= 1'b0;
		cyc(8);
		`CHK("flt held", 1'b1, compare_output)
		rd(OCC_ADDR_STAT, 16'h0001);
		cyc(1);
		`CHK("irq clr", 1'b0, irq)
		rd(OCC_ADDR_MODE, 16'h0010);
		wr(OCC_ADDR_MODE, 16'h0000);
		cyc(2);
		`CHK("flt exit", 1'b1, compare_output_oe_n)
		// Unheld fault: drive low, pin left floating, exit at period start
		wr(OCC_ADDR_CTRL2, 16'h0020);
		compare_raw <= 1'b1;
		fault_pin <= 1'b1;
		cyc(8);
		`CHK("flt lo", 1'b0, compare_output)
		`CHK("flt nodir", 1'b1, compare_output_oe_n)
		fault_pin <= 1'b0;
		cyc(8);
		`CHK("flt wait", 1'b0, compare_output)
		pstart;
		cyc(3);
		`CHK("flt end", 1'b1, compare_output)
		rd(OCC_ADDR_STAT, 16'h0001);
		wr(OCC_ADDR_MODE, 16'h0000);
		// Source 1 is another channel, never this one
		wr(OCC_ADDR_CTRL2, 16'h0081);
		cyc(1);
		`CHK("run idle", 1'b0, timer_run)
		sev;
		cyc(2);
		`CHK("run", 1'b1, timer_run)
		rd(OCC_ADDR_CTRL2, 16'h00C1);
		`CHK("irq mask", 1'b0, irq)
		wr(OCC_ADDR_MASK, 16'h0003);
		cyc(1);
		`CHK("irq trig", 1'b1, irq)
		rd(OCC_ADDR_STAT, 16'h0002);
		wr(OCC_ADDR_CTRL2, 16'h0001);
		sev;
		d = 0;
		do begin
			cyc(1);
			d++;
		end while (sync_pulse !== 1'b1 && d < 4);
		`CHK("sync", 1, d)
		`CHK("sync run", 1'b1, timer_run)
		end_sim;
	end
endmodule
`default_nettype wire
